// File: bench/usb_far_model.sv
/*
  Far side of the hub pins: host on the upstream pair, four devices below.
  Assumes the bench steers host and device drive; released lines fall to
  their pull levels.
*/
`timescale 1ns/1ps
module usb_far_model (
  // host and device commands
  input  wire logic       hostDrive,
  input  wire logic [1:0] hostSym,
  input  wire logic [3:0] devConn,
  input  wire logic [3:0] devLow,
  input  wire logic [3:0] devDrive,
  input  wire logic [7:0] devSym,
  // hub drive
  input  wire logic       upDpOut,
  input  wire logic       upDpOeN,
  input  wire logic       upDmOut,
  input  wire logic       upDmOeN,
  input  wire logic [3:0] dnDpOut,
  input  wire logic [3:0] dnDpOeN,
  input  wire logic [3:0] dnDmOut,
  input  wire logic [3:0] dnDmOeN,
  // resolved lines
  output logic            upDp,
  output logic            upDm,
  output logic [3:0]      dnDp,
  output logic [3:0]      dnDm
);
  always_comb begin
    // pull-up on dp, pull-down on dm when nobody drives
    upDp = !upDpOeN ? upDpOut : (hostDrive ? hostSym[1] : 1'b1);
    upDm = !upDmOeN ? upDmOut : (hostDrive ? hostSym[0] : 1'b0);
    for (int i = 0; i < 4; i++) begin
      // idle level tells the speed: dp high full, dm high low speed
      dnDp[i] = !dnDpOeN[i] ? dnDpOut[i] : (devDrive[i] ? devSym[2*i+1] : devConn[i] & !devLow[i]);
      dnDm[i] = !dnDmOeN[i] ? dnDmOut[i] : (devDrive[i] ? devSym[2*i] : devConn[i] & devLow[i]);
    end
  end
endmodule : usb_far_model

// File: bench/usb_hub_power_status_control_bench.sv
/*
  Self-checking bench for the hub control top: register rows, power,
  overcurrent, interrupt and line repeating.
  Assumes the far side model and the bound checker.
*/
`timescale 1ns/1ps
module usb_hub_power_status_control_bench;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [31:0] expRd;
    logic        expErr;
  } row_t;
  logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0]  paddr, devSym;
  logic [31:0] pwdata, prdata, rd;
  logic        upDp, upDm, upDpOut, upDpOeN, upDmOut, upDmOeN;
  logic [3:0]  dnDp, dnDm, dnDpOut, dnDpOeN, dnDmOut, dnDmOeN;
  logic        overcurrent_in_n, selfPowerMode, clkRateStrap, port_power_switch_n, statusOut, oscAmpEnable;
  logic        hostDrive;
  logic [1:0]  hostSym;
  logic [3:0]  devConn, devLow, devDrive;
  int          miscompares, compares, cycles, n, fsLen, lsLen;
  row_t        rows [14];

  usb_hub_power_status_control u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .irq(irq),
    .upDpIn(upDp), .upDpOut(upDpOut), .upDpOeN(upDpOeN), .upDmIn(upDm), .upDmOut(upDmOut), .upDmOeN(upDmOeN),
    .dnDpIn(dnDp), .dnDpOut(dnDpOut), .dnDpOeN(dnDpOeN), .dnDmIn(dnDm), .dnDmOut(dnDmOut), .dnDmOeN(dnDmOeN),
    .overcurrent_in_n(overcurrent_in_n), .selfPowerMode(selfPowerMode), .clkRateStrap(clkRateStrap),
    .port_power_switch_n(port_power_switch_n), .statusOut(statusOut), .oscAmpEnable(oscAmpEnable)
  );
  usb_far_model u_far (
    .hostDrive(hostDrive), .hostSym(hostSym), .devConn(devConn), .devLow(devLow), .devDrive(devDrive),
    .devSym(devSym), .upDpOut(upDpOut), .upDpOeN(upDpOeN), .upDmOut(upDmOut), .upDmOeN(upDmOeN),
    .dnDpOut(dnDpOut), .dnDpOeN(dnDpOeN), .dnDmOut(dnDmOut), .dnDmOeN(dnDmOeN),
    .upDp(upDp), .upDm(upDm), .dnDp(dnDp), .dnDm(dnDm)
  );

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      $display("BAD %0t timeout", $time);
      end_of_test();
    end
  end

  task automatic chkBit(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chkBit

  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h", $time, msg, got);
    end
  endtask : chkWord

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // device sends K, then SE0, then releases; len counts upstream drive after release
  task automatic upPkt(input int p, input logic [1:0] k, output int len);
    @(posedge clk_sys);
    devDrive[p] <= 1'b1;
    devSym[2*p +: 2] <= k;
    tick(6);
    chkWord({29'h0, upDpOeN, upDpOut, upDmOut}, 32'h1, "up K");
    @(posedge clk_sys);
    devSym[2*p +: 2] <= hub_pkg::LINE_SE0;
    tick(12);
    @(posedge clk_sys);
    devDrive[p] <= 1'b0;
    for (len = 0; len < 400 && upDpOeN === 1'b0; len++) tick(1);
  endtask : upPkt

  initial begin
    {psel, penable, pwrite, paddr, pwdata, rst_b, hostDrive, devConn, devLow, devDrive, devSym} = '0;
    {overcurrent_in_n, selfPowerMode, clkRateStrap} = 3'h7;
    hostSym = hub_pkg::LINE_J;
    {cycles, miscompares, compares} = '0;
    rows = '{'{1'b1, 8'h08, 32'h7, 32'h0, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
             '{1'b0, 8'h0c, 32'h0, 32'h0, 1'b0}, '{1'b1, 8'h0c, 32'h7, 32'h0, 1'b0},
             '{1'b0, 8'h0c, 32'h0, 32'h7, 1'b0}, '{1'b0, 8'h14, 32'h0, 32'h0, 1'b1},
             '{1'b1, 8'h14, 32'h5, 32'h0, 1'b1}, '{1'b0, 8'h04, 32'h0, 32'h0a, 1'b0},
             '{1'b1, 8'h00, 32'h5, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h1e, 1'b0},
             '{1'b1, 8'h00, 32'hc, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h0e, 1'b0},
             '{1'b1, 8'h00, 32'h2, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h0a, 1'b0}};
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    tick(12);
    chkBit(port_power_switch_n, 1'b1, "power at reset");
    chkBit(statusOut, 1'b0, "status at reset");
    chkBit(irq, 1'b0, "irq at reset");
    chkBit(&{upDpOeN, upDmOeN, dnDpOeN, dnDmOeN}, 1'b1, "drive at reset");
    chkBit(oscAmpEnable, 1'b1, "osc mode");
    $display("test reset done");
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].data);
      if (!rows[i].wr) chkWord(rd, rows[i].expRd, "row read");
      chkBit(err, rows[i].expErr, "row error");
    end
    $display("test rows done");
    apb(1'b1, hub_pkg::OFF_CTRL, 32'h1);
    tick(3);
    chkBit(port_power_switch_n, 1'b0, "power on");
    @(posedge clk_sys);
    overcurrent_in_n <= 1'b0;
    tick(5);
    chkBit(port_power_switch_n, 1'b1, "overcurrent off");
    apb(1'b0, hub_pkg::OFF_STATUS, 32'h0);
    chkWord(rd, 32'h0b, "overcurrent status");
    apb(1'b0, hub_pkg::OFF_IRQ_STAT, 32'h0);
    chkWord(rd, 32'h1, "overcurrent change");
    chkBit(irq, 1'b1, "irq raised");
    apb(1'b1, hub_pkg::OFF_CTRL, 32'h1);
    tick(3);
    chkBit(port_power_switch_n, 1'b1, "overcurrent wins");
    @(posedge clk_sys);
    overcurrent_in_n <= 1'b1;
    tick(5);
    apb(1'b1, hub_pkg::OFF_IRQ_STAT, 32'h7);
    tick(2);
    chkBit(irq, 1'b0, "irq cleared");
    apb(1'b0, hub_pkg::OFF_IRQ_STAT, 32'h0);
    chkWord(rd, 32'h0, "change cleared");
    $display("test overcurrent done");
    apb(1'b1, hub_pkg::OFF_IRQ_MASK, 32'h0);
    @(posedge clk_sys);
    selfPowerMode <= 1'b0;
    tick(5);
    apb(1'b0, hub_pkg::OFF_STATUS, 32'h0);
    chkWord(rd, 32'h08, "bus powered");
    chkBit(irq, 1'b0, "irq masked");
    apb(1'b1, hub_pkg::OFF_IRQ_MASK, 32'h2);
    tick(2);
    chkBit(irq, 1'b1, "irq unmasked");
    apb(1'b1, hub_pkg::OFF_IRQ_STAT, 32'h2);
    tick(2);
    chkBit(irq, 1'b0, "mode cleared");
    $display("test mode done");
    apb(1'b1, hub_pkg::OFF_CTRL, 32'h5);
    apb(1'b1, hub_pkg::OFF_CTRL, 32'h10);
    tick(3);
    chkBit(port_power_switch_n, 1'b1, "init power");
    chkBit(statusOut, 1'b0, "init status");
    $display("test init done");
    apb(1'b1, hub_pkg::OFF_CTRL, 32'h1);
    @(posedge clk_sys);
    devConn <= 4'h3;
    devLow  <= 4'h2;
    tick(30);
    apb(1'b0, hub_pkg::OFF_PORTS, 32'h0);
    chkWord(rd, 32'h23, "port speeds");
    @(posedge clk_sys);
    hostDrive <= 1'b1;
    hostSym   <= hub_pkg::LINE_K;
    tick(6);
    chkWord({24'h0, dnDpOeN, dnDmOeN}, 32'hcc, "down drive");
    chkWord({28'h0, dnDpOut[1:0], dnDmOut[1:0]}, 32'h9, "down K");
    @(posedge clk_sys);
    hostSym <= hub_pkg::LINE_SE0;
    tick(12);
    @(posedge clk_sys);
    hostSym <= hub_pkg::LINE_J;
    tick(12);
    @(posedge clk_sys);
    hostDrive <= 1'b0;
    for (n = 0; n < 300 && dnDpOeN !== 4'hf; n++) tick(1);
    chkBit(&dnDpOeN, 1'b1, "down end");
    $display("test downstream done");
    upPkt(0, hub_pkg::LINE_K, fsLen);
    upPkt(1, hub_pkg::LINE_J, lsLen);
    chkBit(fsLen <= 2 * hub_pkg::CLK_KHZ / hub_pkg::FS_KHZ + 8, 1'b1, "full speed end");
    chkBit(lsLen >= hub_pkg::CLK_KHZ / hub_pkg::LS_KHZ / 2, 1'b1, "low speed end");
    $display("test upstream done");
    end_of_test();
  end
endmodule : usb_hub_power_status_control_bench

// File: bench/usb_hub_power_status_control_checker.sv
/*
  Port-level assertions for the hub control top.
  Assumes it is bound to that top and sees only its ports.
*/
`timescale 1ns/1ps
module usb_hub_power_status_control_checker (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_b,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic        overcurrent_in_n,
  input wire logic        clkRateStrap,
  input wire logic        port_power_switch_n,
  input wire logic        statusOut,
  input wire logic        oscAmpEnable,
  input wire logic        upDpOeN,
  input wire logic [3:0]  dnDpOeN,
  input wire logic [3:0]  dnDmOeN
);
  logic acc;
  logic mapped;
  logic ctrlWr;
  assign acc    = psel && penable;
  assign mapped = (paddr <= hub_pkg::OFF_PORTS) && (paddr[1:0] == 2'h0);
  assign ctrlWr = acc && pwrite && (paddr == hub_pkg::OFF_CTRL);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_ready_zero_wait: assert property (acc |-> pready) else $error("pready late");
  a_err_unmapped: assert property (acc |-> (pslverr == !mapped)) else $error("pslverr wrong");
  a_ovc_power_off: assert property (!overcurrent_in_n [*5] |-> port_power_switch_n)
    else $error("power kept on overcurrent");
  a_power_on_cause: assert property ($fell(port_power_switch_n) |->
    $past(ctrlWr && pwdata[0], 1) || $past(ctrlWr && pwdata[0], 2)) else $error("power on uncommanded");
  a_power_clear: assert property (ctrlWr && (pwdata[1] || pwdata[4]) |-> ##[1:2] port_power_switch_n)
    else $error("power not cleared");
  a_status_follow: assert property (ctrlWr |=> statusOut ==
    ($past(pwdata[2]) && !$past(pwdata[3]) && !$past(pwdata[4]))) else $error("status output wrong");
  a_strap_osc: assert property (clkRateStrap [*8] |-> oscAmpEnable) else $error("osc mode wrong");
  a_unpowered_quiet: assert property (port_power_switch_n [*3] |-> (&dnDpOeN) && (&dnDmOeN))
    else $error("unpowered port driven");
  a_one_direction: assert property (!upDpOeN |-> &dnDpOeN) else $error("both directions driven");
endmodule : usb_hub_power_status_control_checker

bind usb_hub_power_status_control usb_hub_power_status_control_checker u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .overcurrent_in_n(overcurrent_in_n),
  .clkRateStrap(clkRateStrap), .port_power_switch_n(port_power_switch_n), .statusOut(statusOut),
  .oscAmpEnable(oscAmpEnable), .upDpOeN(upDpOeN), .dnDpOeN(dnDpOeN), .dnDmOeN(dnDmOeN)
);

// File: pkg/hub_pkg.sv
/*
  Shared constants for the hub control block: register map, field
  positions, reset values, line symbols and bit-rate figures.
  Assumes a 32-bit APB register bus and a single system clock.
*/
package hub_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFF_PORTS    = 8'h10;

  // control register fields
  localparam int CTRL_PWR_SET   = 0;
  localparam int CTRL_PWR_CLR   = 1;
  localparam int CTRL_CONFIGURED = 2;
  localparam int CTRL_SUSPEND   = 3;
  localparam int CTRL_INIT      = 4;

  // status register fields
  localparam int ST_OVC_ACTIVE  = 0;
  localparam int ST_SELF_POWER  = 1;
  localparam int ST_POWER_ON    = 2;
  localparam int ST_CLK6_MODE   = 3;
  localparam int ST_STAT_OUT    = 4;
  localparam int ST_BUSY        = 5;

  // interrupt status / mask fields
  localparam int IRQ_W          = 3;
  localparam int IRQ_OVC_CHANGE = 0;
  localparam int IRQ_MODE_CHANGE = 1;
  localparam int IRQ_CONN_CHANGE = 2;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // ports register fields
  localparam int PORTS_CONN_LSB = 0;
  localparam int PORTS_LOW_LSB  = 4;

  // line symbols as {dp, dm}, full-speed polarity
  localparam logic [1:0] LINE_J   = 2'h2;
  localparam logic [1:0] LINE_K   = 2'h1;
  localparam logic [1:0] LINE_SE0 = 2'h0;

  // bit-rate figures in kHz
  localparam int CLK_KHZ = 125000;
  localparam int FS_KHZ  = 12000;
  localparam int LS_KHZ  = 1500;
  localparam int ACC_W   = 18;

  typedef enum logic [1:0] {
    REP_IDLE = 2'b00,
    REP_DOWN = 2'b01,
    REP_UP   = 2'b10,
    REP_EOPJ = 2'b11
  } repMode_t;

endpackage : hub_pkg

// File: pkg/hub_repeater_if.sv
/*
  Connection between the hub control top and its repeater core:
  synchronised line states, port power, bit ticks and port status.
  Assumes both sides run on clk_sys.
*/
`timescale 1ns/1ps
interface hub_repeater_if;
  logic            portPowered;
  logic            fsTick;
  logic            lsTick;
  logic [1:0]      upLine;
  logic [3:0][1:0] dnLine;
  logic [1:0]      upOut;
  logic            upOeN;
  logic [3:0][1:0] dnOut;
  logic [3:0]      dnOeN;
  logic [3:0]      connected;
  logic [3:0]      lowSpeed;
  logic            busy;

  modport ctrl (
    output portPowered, fsTick, lsTick, upLine, dnLine,
    input  upOut, upOeN, dnOut, dnOeN, connected, lowSpeed, busy
  );
  modport rep (
    input  portPowered, fsTick, lsTick, upLine, dnLine,
    output upOut, upOeN, dnOut, dnOeN, connected, lowSpeed, busy
  );
endinterface : hub_repeater_if

// File: rtl/hub_repeater.sv
/*
  Repeater core: passes J/K/SE0 line states from the upstream port to
  the connected downstream ports and from one of them back up, while port power is on.
  Assumes line inputs already synchronised and bit ticks from the top.
*/
`timescale 1ns/1ps
module hub_repeater (
  // clock and reset
  input wire logic   clk_sys,
  input wire logic   rstSync_b,
  // control side
  hub_repeater_if.rep bus
);

  typedef struct packed {
    hub_pkg::repMode_t mode;
    logic [1:0]        src;
    logic              sawSe0;
    logic              eopLow;
    logic [3:0]        conn;
    logic [3:0]        low;
    logic [1:0]        upOut;
    logic              upOeN;
    logic [3:0][1:0]   dnOut;
    logic [3:0]        dnOeN;
  } repState_t;

  repState_t s;
  repState_t next_s;

  // low-speed ports see J and K with dp and dm swapped
  function automatic logic [1:0] portSym(input logic [1:0] sym, input logic low);
    portSym = low ? {sym[0], sym[1]} : sym;
  endfunction : portSym

  always_comb begin
    logic found;
    logic [1:0] line;
    logic tick;
    found  = 1'b0;
    line   = hub_pkg::LINE_J;
    tick   = s.eopLow ? bus.lsTick : bus.fsTick;
    next_s = s;
    case (s.mode)
      hub_pkg::REP_IDLE: begin
        next_s.upOeN = 1'b1;
        next_s.dnOeN = 4'hf;
        for (int i = 0; i < 4; i++) begin
          if (bus.dnLine[i] == hub_pkg::LINE_SE0) begin
            next_s.conn[i] = 1'b0;
          end else if (!s.conn[i]) begin
            next_s.conn[i] = 1'b1;
            next_s.low[i]  = (bus.dnLine[i] == hub_pkg::LINE_K);
          end
        end
        if (bus.upLine == hub_pkg::LINE_K) begin
          next_s.mode   = hub_pkg::REP_DOWN;
          next_s.sawSe0 = 1'b0;
          next_s.eopLow = 1'b0;
        end else begin
          for (int i = 0; i < 4; i++) begin
            if (!found && bus.portPowered && s.conn[i] &&
                bus.dnLine[i] == portSym(hub_pkg::LINE_K, s.low[i])) begin
              found         = 1'b1;
              next_s.src    = 2'(i);
              next_s.eopLow = s.low[i];
              next_s.sawSe0 = 1'b0;
              next_s.mode   = hub_pkg::REP_UP;
            end
          end
        end
      end
      hub_pkg::REP_DOWN: begin
        line = bus.upLine;
        for (int i = 0; i < 4; i++) begin
          next_s.dnOut[i] = portSym(line, s.low[i]);
          next_s.dnOeN[i] = ~(bus.portPowered & s.conn[i]);
        end
        if (line == hub_pkg::LINE_SE0) begin
          next_s.sawSe0 = 1'b1;
        end else if (s.sawSe0 && line == hub_pkg::LINE_J) begin
          next_s.mode = hub_pkg::REP_EOPJ;
        end
      end
      hub_pkg::REP_UP: begin
        line          = portSym(bus.dnLine[s.src], s.low[s.src]);
        next_s.upOut  = line;
        next_s.upOeN  = 1'b0;
        if (line == hub_pkg::LINE_SE0) begin
          next_s.sawSe0 = 1'b1;
        end else if (s.sawSe0 && line == hub_pkg::LINE_J) begin
          next_s.mode = hub_pkg::REP_EOPJ;
        end
      end
      hub_pkg::REP_EOPJ: begin
        // drive idle J for at least one full bit time, then release
        next_s.upOut = hub_pkg::LINE_J;
        for (int i = 0; i < 4; i++) begin
          next_s.dnOut[i] = portSym(hub_pkg::LINE_J, s.low[i]);
        end
        if (tick && s.sawSe0) begin
          next_s.sawSe0 = 1'b0;
        end else if (tick) begin
          next_s.mode  = hub_pkg::REP_IDLE;
          next_s.upOeN = 1'b1;
          next_s.dnOeN = 4'hf;
        end
      end
      default: begin
        next_s.mode = hub_pkg::REP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      s        <= '0;
      s.mode   <= hub_pkg::REP_IDLE;
      s.upOut  <= hub_pkg::LINE_J;
      s.upOeN  <= 1'b1;
      s.dnOeN  <= 4'hf;
    end else begin
      s <= next_s;
    end
  end

  assign bus.upOut     = s.upOut;
  assign bus.upOeN     = s.upOeN;
  assign bus.dnOut     = s.dnOut;
  assign bus.dnOeN     = s.dnOeN;
  assign bus.connected = s.conn;
  assign bus.lowSpeed  = s.low;
  assign bus.busy      = (s.mode != hub_pkg::REP_IDLE);

endmodule : hub_repeater

// File: rtl/usb_hub_power_status_control.sv
/*
  Hub control top: APB registers, port power switch, overcurrent and
  power-mode inputs, enumeration status output, interrupt, bit-rate
  enables and the repeater core.
  Assumes an APB master on clk_sys (125 MHz) and asynchronous pins.
*/
`timescale 1ns/1ps
module usb_hub_power_status_control (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // interrupt
  output logic             irq,
  // upstream_port pins
  input  wire logic        upDpIn,
  output logic             upDpOut,
  output logic             upDpOeN,
  input  wire logic        upDmIn,
  output logic             upDmOut,
  output logic             upDmOeN,
  // downstream port pins, bit i is port i+1
  input  wire logic [3:0]  dnDpIn,
  output logic [3:0]       dnDpOut,
  output logic [3:0]       dnDpOeN,
  input  wire logic [3:0]  dnDmIn,
  output logic [3:0]       dnDmOut,
  output logic [3:0]       dnDmOeN,
  // power and status pins
  input  wire logic        overcurrent_in_n,
  input  wire logic        selfPowerMode,
  input  wire logic        clkRateStrap,
  output logic             port_power_switch_n,
  output logic             statusOut,
  output logic             oscAmpEnable
);

  typedef struct packed {
    logic [1:0]         ovcSync;
    logic [1:0]         modeSync;
    logic [1:0]         strapSync;
    logic [1:0][1:0]    upSync;
    logic [1:0][3:0]    dpSync;
    logic [1:0][3:0]    dmSync;
    logic               clk6Mode;
    logic               powerOn;
    logic               configured;
    logic               suspended;
    logic               statLed;
    logic               ovcPrev;
    logic               modePrev;
    logic [3:0]         connPrev;
    logic [hub_pkg::IRQ_W-1:0] irqStat;
    logic [hub_pkg::IRQ_W-1:0] irqMask;
    logic [31:0]        rdata;
    logic [hub_pkg::ACC_W-1:0] fsAcc;
    logic [hub_pkg::ACC_W-1:0] lsAcc;
    logic               fsTick;
    logic               lsTick;
  } top_t;

  localparam logic [hub_pkg::ACC_W-1:0] CLK_STEP = hub_pkg::ACC_W'(hub_pkg::CLK_KHZ);
  localparam logic [hub_pkg::ACC_W-1:0] FS_STEP  = hub_pkg::ACC_W'(hub_pkg::FS_KHZ);
  localparam logic [hub_pkg::ACC_W-1:0] LS_STEP  = hub_pkg::ACC_W'(hub_pkg::LS_KHZ);

  logic [1:0] rstPipe;
  logic       rstSync_b;
  top_t       s;
  top_t       next_s;
  logic       setup;
  logic       access;
  logic       mapped;
  logic       ovcActive;

  hub_repeater_if rbus ();

  hub_repeater u_repeater (
    .clk_sys   (clk_sys),
    .rstSync_b (rstSync_b),
    .bus       (rbus.rep)
  );

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync_b = rstPipe[1];

  assign setup     = psel & ~penable;
  assign access    = psel & penable;
  assign mapped    = (paddr == hub_pkg::OFF_CTRL) || (paddr == hub_pkg::OFF_STATUS) ||
                     (paddr == hub_pkg::OFF_IRQ_STAT) || (paddr == hub_pkg::OFF_IRQ_MASK) ||
                     (paddr == hub_pkg::OFF_PORTS);
  assign ovcActive = ~s.ovcSync[1];

  always_comb begin
    logic [hub_pkg::IRQ_W-1:0] ev;
    logic [hub_pkg::IRQ_W-1:0] clr;
    logic [31:0]               rd;
    logic                      wr;
    ev     = '0;
    clr    = '0;
    rd     = 32'h0;
    wr     = access & pwrite & mapped;
    next_s = s;

    // pin synchronisers
    next_s.ovcSync   = {s.ovcSync[0], overcurrent_in_n};
    next_s.modeSync  = {s.modeSync[0], selfPowerMode};
    next_s.strapSync = {s.strapSync[0], clkRateStrap};
    next_s.upSync    = {s.upSync[0], {upDpIn, upDmIn}};
    next_s.dpSync    = {s.dpSync[0], dnDpIn};
    next_s.dmSync    = {s.dmSync[0], dnDmIn};
    next_s.clk6Mode  = s.strapSync[1];

    // bit-rate enables
    next_s.fsTick = 1'b0;
    next_s.lsTick = 1'b0;
    if (s.fsAcc + FS_STEP >= CLK_STEP) begin
      next_s.fsAcc  = s.fsAcc + FS_STEP - CLK_STEP;
      next_s.fsTick = 1'b1;
    end else begin
      next_s.fsAcc = s.fsAcc + FS_STEP;
    end
    if (s.lsAcc + LS_STEP >= CLK_STEP) begin
      next_s.lsAcc  = s.lsAcc + LS_STEP - CLK_STEP;
      next_s.lsTick = 1'b1;
    end else begin
      next_s.lsAcc = s.lsAcc + LS_STEP;
    end

    // register writes
    if (wr && paddr == hub_pkg::OFF_CTRL) begin
      if (pwdata[hub_pkg::CTRL_PWR_SET]) begin
        next_s.powerOn = 1'b1;
      end
      if (pwdata[hub_pkg::CTRL_PWR_CLR]) begin
        next_s.powerOn = 1'b0;
      end
      next_s.configured = pwdata[hub_pkg::CTRL_CONFIGURED];
      next_s.suspended  = pwdata[hub_pkg::CTRL_SUSPEND];
      if (pwdata[hub_pkg::CTRL_INIT]) begin
        next_s.powerOn    = 1'b0;
        next_s.configured = 1'b0;
        next_s.suspended  = 1'b0;
      end
    end
    if (wr && paddr == hub_pkg::OFF_IRQ_MASK) begin
      next_s.irqMask = pwdata[hub_pkg::IRQ_W-1:0];
    end
    if (wr && paddr == hub_pkg::OFF_IRQ_STAT) begin
      clr = pwdata[hub_pkg::IRQ_W-1:0];
    end

    // overcurrent wins over any power-on request
    if (ovcActive) begin
      next_s.powerOn = 1'b0;
    end

    // events into sticky bits, set beats clear
    next_s.ovcPrev  = ovcActive;
    next_s.modePrev = s.modeSync[1];
    next_s.connPrev = rbus.connected;
    ev[hub_pkg::IRQ_OVC_CHANGE]  = ovcActive != s.ovcPrev;
    ev[hub_pkg::IRQ_MODE_CHANGE] = s.modeSync[1] != s.modePrev;
    ev[hub_pkg::IRQ_CONN_CHANGE] = rbus.connected != s.connPrev;
    next_s.irqStat = (s.irqStat & ~clr) | ev;

    // enumeration status pin
    next_s.statLed = next_s.configured & ~next_s.suspended;

    // read data captured in the setup cycle
    case (paddr)
      hub_pkg::OFF_CTRL: begin
        rd[hub_pkg::CTRL_CONFIGURED] = s.configured;
        rd[hub_pkg::CTRL_SUSPEND]    = s.suspended;
      end
      hub_pkg::OFF_STATUS: begin
        rd[hub_pkg::ST_OVC_ACTIVE] = ovcActive;
        rd[hub_pkg::ST_SELF_POWER] = s.modeSync[1];
        rd[hub_pkg::ST_POWER_ON]   = s.powerOn;
        rd[hub_pkg::ST_CLK6_MODE]  = s.clk6Mode;
        rd[hub_pkg::ST_STAT_OUT]   = s.statLed;
        rd[hub_pkg::ST_BUSY]       = rbus.busy;
      end
      hub_pkg::OFF_IRQ_STAT: begin
        rd[hub_pkg::IRQ_W-1:0] = s.irqStat;
      end
      hub_pkg::OFF_IRQ_MASK: begin
        rd[hub_pkg::IRQ_W-1:0] = s.irqMask;
      end
      hub_pkg::OFF_PORTS: begin
        rd[hub_pkg::PORTS_CONN_LSB +: 4] = rbus.connected;
        rd[hub_pkg::PORTS_LOW_LSB +: 4]  = rbus.lowSpeed;
      end
      default: begin
        rd = 32'h0;
      end
    endcase
    if (setup) begin
      next_s.rdata = pwrite ? 32'h0 : rd;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      s          <= '0;
      s.ovcSync  <= 2'h3;
      s.upSync   <= {hub_pkg::LINE_J, hub_pkg::LINE_J};
      s.irqMask  <= hub_pkg::IRQ_MASK_RST;
    end else begin
      s <= next_s;
    end
  end

  // repeater hookup
  assign rbus.portPowered = s.powerOn;
  assign rbus.fsTick      = s.fsTick;
  assign rbus.lsTick      = s.lsTick;
  assign rbus.upLine      = s.upSync[1];
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      rbus.dnLine[i] = {s.dpSync[1][i], s.dmSync[1][i]};
      dnDpOut[i]     = rbus.dnOut[i][1];
      dnDmOut[i]     = rbus.dnOut[i][0];
    end
  end
  assign dnDpOeN = rbus.dnOeN;
  assign dnDmOeN = rbus.dnOeN;
  assign upDpOut = rbus.upOut[1];
  assign upDmOut = rbus.upOut[0];
  assign upDpOeN = rbus.upOeN;
  assign upDmOeN = rbus.upOeN;

  // outputs
  assign pready              = access;
  assign pslverr             = access & ~mapped;
  assign prdata              = s.rdata;
  assign irq                 = |(s.irqStat & s.irqMask);
  assign port_power_switch_n = ~s.powerOn;
  assign statusOut           = s.statLed;
  assign oscAmpEnable        = s.clk6Mode;

endmodule : usb_hub_power_status_control
